/* hdl/sp2_cfg_pkg.sv */
// Constants shared by the second serial port option logic.
// Assumes a 25 MHz core clock and an 8-bit register port.
package sp2_cfg_pkg;
    // Register offsets
    localparam logic [7:0] OFS_MODE = 8'hf0;
    localparam logic [7:0] OFS_IR_OPT = 8'hf1;
    localparam logic [7:0] OFS_HD_TIMEOUT = 8'hf2;
    localparam logic [7:0] OFS_STATUS = 8'hf3;
    // Values after reset
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_IR_OPT = 8'h02;
    localparam logic [7:0] RST_HD_TIMEOUT = 8'h03;
    // Mode register fields
    localparam int MODE_MIDI_BIT = 0;
    localparam int MODE_HSPEED_BIT = 1;
    localparam int MODE_TX_IDLE_BIT = 7;
    // Infrared option fields
    localparam int IR_RX_POL_BIT = 0;
    localparam int IR_TX_POL_BIT = 1;
    localparam int IR_DUPLEX_BIT = 2;
    localparam int IR_MODE_LSB = 3;
    localparam int IR_MODE_MSB = 5;
    // Infrared scheme codes
    localparam logic [2:0] IR_CODE_STD = 3'h0;
    localparam logic [2:0] IR_CODE_IRDA = 3'h3;
    localparam logic [2:0] IR_CODE_ASK = 3'h2;
    // Status register fields
    localparam int STAT_BLANK_BIT = 0;
    localparam int STAT_RX_BIT = 1;
    localparam int STAT_RSVD_BIT = 2;
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int BLANK_STEP_US = 100;
    localparam int BLANK_STEP_CYCLES = BLANK_STEP_US * CLK_MHZ;
    localparam int BIT_TICKS = 16;
    localparam int IRDA_PULSE_TICKS = 3;
    localparam int ASK_HALF_CYCLES = 25;
    localparam int SYNC_STAGES = 3;
    // Decoded infrared scheme, one-hot
    typedef enum logic [3:0]
    {
        SCHEME_STD = 4'h1,
        SCHEME_IRDA = 4'h2,
        SCHEME_ASK = 4'h4,
        SCHEME_RSVD = 4'h8
    } scheme_t;
endpackage

/* hdl/pin_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous pin on the input.
`timescale 1ns/1ns
module pin_sync
(
    input wire logic clk, // Core clock
    input wire logic nrst, // Async reset, active low
    input wire logic pin, // Raw pin level
    input wire logic init, // Unused; level resets to 0
    output logic level // Filtered level
);
    import sp2_cfg_pkg::*;

    logic [SYNC_STAGES-1:0] stage; // Sync chain

    // Chain of three flops; first only feeds second
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stage <= '0;
        else
            stage <= {stage[SYNC_STAGES-2:0], pin};
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            level <= 1'b0;
        else if (stage[1] == stage[2])
            level <= stage[2];
    end
endmodule

/* hdl/blank_timer.sv */
// Receiver blanking timer for half duplex infrared.
// Assumes busy is a same-clock level from the transmitter.
`timescale 1ns/1ns
module blank_timer #(
    parameter int STEP_CYCLES = sp2_cfg_pkg::BLANK_STEP_CYCLES
)
(
    input wire logic clk, // Core clock
    input wire logic nrst, // Async reset, active low
    input wire logic busy, // Transmitter active
    input wire logic [7:0] steps, // Extension in steps
    output logic blank // Receiver blanked
);
    import sp2_cfg_pkg::*;

    logic [19:0] pre; // Cycles within a step
    logic [7:0] left; // Steps remaining
    logic next_blank; // Blank for next cycle

    // Reload while busy, then count steps down
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre <= '0;
            left <= '0;
        end
        else if (busy)
        begin
            pre <= '0;
            left <= steps;
        end
        else if (left != 8'h00)
        begin
            if (pre == 20'(STEP_CYCLES - 1))
            begin
                pre <= '0;
                left <= left - 8'h01;
            end
            else
                pre <= pre + 20'h00001;
        end
    end

    assign next_blank = busy || (left != 8'h00);

    // Registered blanking flag
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            blank <= 1'b0;
        else
            blank <= next_blank;
    end
endmodule

/* hdl/serial_port_ir_option_config.sv */
// Option registers and infrared line shaping for the second serial port.
// Assumes a UART core supplying serial data, a 16x baud tick and a
// transmitter-active level, all on clk; the receive pin is asynchronous.
`timescale 1ns/1ns

module serial_port_ir_option_config #(
    parameter int STEP_CYCLES = sp2_cfg_pkg::BLANK_STEP_CYCLES
)
(
    input wire logic clk, // Core clock, 25 MHz
    input wire logic nrst, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    output logic [7:0] reg_rdata, // Read data, next cycle
    input wire logic uart_txd, // Serial data from UART
    input wire logic uart_tx_active, // UART transmitting
    input wire logic baud16_tick, // 16x baud tick
    input wire logic ir_rx_pin, // Receive pin, async
    output logic uart_rxd, // Serial data to UART
    output logic second_port_transmit_pin, // Transmit pin
    output logic second_port_transmit_oe, // Transmit pin enable
    output logic midi_enable, // MIDI support on
    output logic high_speed_enable, // High speed on
    output logic irda_select, // IrDA scheme active
    output logic ask_select, // ASK scheme active
    output logic rx_blanked // Receiver blanked now
);
    import sp2_cfg_pkg::*;

    logic [7:0] serial_port_two_mode; // Mode register
    logic [7:0] infrared_option; // Infrared options
    logic [7:0] infrared_half_duplex_timeout; // Blank steps
    scheme_t scheme; // Decoded scheme
    logic rx_sync; // Synchronised receive pin
    logic rx_level; // Receive after polarity
    logic rx_active; // Receive pulse not blanked
    logic blank; // Timer blanking
    logic blank_on; // Blanking in effect
    logic [3:0] tx_phase; // Tick within a zero bit
    logic [4:0] rx_stretch; // Ticks left of a zero bit
    logic [4:0] ask_div; // Carrier divider
    logic ask_carrier; // Carrier level
    logic tx_line; // Line before polarity
    logic transmit_idle_select; // Idle pin tristate
    logic next_pin; // Next transmit pin level
    logic next_oe; // Next transmit pin enable
    logic next_rxd; // Next UART receive level
    logic [7:0] status; // Live status byte

    assign transmit_idle_select = serial_port_two_mode[MODE_TX_IDLE_BIT];

    // Mode register write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            serial_port_two_mode <= RST_MODE;
        else if (reg_write && reg_addr == OFS_MODE)
            serial_port_two_mode <= reg_wdata; // Reserved bits kept as written
    end

    // Infrared option register write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            infrared_option <= RST_IR_OPT;
        else if (reg_write && reg_addr == OFS_IR_OPT)
            infrared_option <= reg_wdata; // Reserved bits kept as written
    end

    // Half duplex timeout register write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            infrared_half_duplex_timeout <= RST_HD_TIMEOUT;
        else if (reg_write && reg_addr == OFS_HD_TIMEOUT)
            infrared_half_duplex_timeout <= reg_wdata;
    end

    // Status byte: blanking, receive level, reserved scheme
    always_comb
    begin
        status = 8'h00;
        status[STAT_BLANK_BIT] = blank_on;
        status[STAT_RX_BIT] = rx_level;
        status[STAT_RSVD_BIT] = (scheme == SCHEME_RSVD);
    end

    // Read data, one cycle after the strobe only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_read)
        begin
            case (reg_addr)
                OFS_MODE: reg_rdata <= serial_port_two_mode;
                OFS_IR_OPT: reg_rdata <= infrared_option;
                OFS_HD_TIMEOUT: reg_rdata <= infrared_half_duplex_timeout;
                OFS_STATUS: reg_rdata <= status;
                default: reg_rdata <= 8'h00; // Unmapped reads zero
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // Scheme decode; reserved codes behave as standard
    always_comb
    begin
        case (infrared_option[IR_MODE_MSB:IR_MODE_LSB])
            IR_CODE_STD: scheme = SCHEME_STD;
            IR_CODE_IRDA: scheme = SCHEME_IRDA;
            IR_CODE_ASK: scheme = SCHEME_ASK;
            default: scheme = SCHEME_RSVD;
        endcase
    end

    // Receive pin synchroniser
    pin_sync u_rx_sync
    (
        .clk(clk),
        .nrst(nrst),
        .pin(ir_rx_pin),
        .init(1'b0),
        .level(rx_sync)
    );

    // Blanking timer runs off transmit activity
    blank_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_blank
    (
        .clk(clk),
        .nrst(nrst),
        .busy(uart_tx_active),
        .steps(infrared_half_duplex_timeout),
        .blank(blank)
    );

    // Blanking only counts in half duplex
    assign blank_on = infrared_option[IR_DUPLEX_BIT] && blank;

    // Receive polarity: active low inverts the pin
    assign rx_level = rx_sync ^ infrared_option[IR_RX_POL_BIT];

    // Receive pulses suppressed while blanked
    assign rx_active = rx_level && !blank_on;

    // IrDA transmit: tick counter within each zero bit
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tx_phase <= 4'h0;
        else if (uart_txd)
            tx_phase <= 4'h0; // Realign on mark
        else if (baud16_tick)
            tx_phase <= tx_phase + 4'h1; // Wraps per bit
    end

    // ASK carrier divider
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ask_div <= 5'h00;
            ask_carrier <= 1'b0;
        end
        else if (ask_div == 5'(ASK_HALF_CYCLES - 1))
        begin
            ask_div <= 5'h00;
            ask_carrier <= !ask_carrier;
        end
        else
            ask_div <= ask_div + 5'h01;
    end

    // IR receive: a pulse stretches into one zero bit
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rx_stretch <= 5'h00;
        else if (rx_active)
            rx_stretch <= 5'(BIT_TICKS);
        else if (baud16_tick && rx_stretch != 5'h00)
            rx_stretch <= rx_stretch - 5'h01;
    end

    // Line shaping per scheme
    always_comb
    begin
        tx_line = uart_txd;
        next_rxd = rx_level;
        case (scheme)
            SCHEME_IRDA:
            begin
                // Short pulse at start of each zero bit
                tx_line = !uart_txd && (tx_phase < 4'(IRDA_PULSE_TICKS));
                next_rxd = (rx_stretch == 5'h00) && !rx_active;
            end
            SCHEME_ASK:
            begin
                // Carrier bursts during zero bits
                tx_line = !uart_txd && ask_carrier;
                next_rxd = (rx_stretch == 5'h00) && !rx_active;
            end
            SCHEME_STD:
            begin
                tx_line = uart_txd;
                next_rxd = rx_level || blank_on;
            end
            default:
            begin
                tx_line = uart_txd; // Reserved acts as standard
                next_rxd = rx_level || blank_on;
            end
        endcase
    end

    // Transmit pin level and enable, idle handling
    always_comb
    begin
        next_oe = 1'b1;
        if (!uart_tx_active)
        begin
            next_pin = 1'b0;
            next_oe = !transmit_idle_select;
        end
        else if (scheme == SCHEME_IRDA || scheme == SCHEME_ASK)
            next_pin = tx_line ^ infrared_option[IR_TX_POL_BIT];
        else
            next_pin = tx_line;
    end

    // Transmit pin registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            second_port_transmit_pin <= 1'b0;
            second_port_transmit_oe <= 1'b1;
        end
        else
        begin
            second_port_transmit_pin <= next_pin;
            second_port_transmit_oe <= next_oe;
        end
    end

    // UART receive register, idles at mark
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            uart_rxd <= 1'b1;
        else
            uart_rxd <= next_rxd;
    end

    // Mode and status outputs
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            midi_enable <= 1'b0;
            high_speed_enable <= 1'b0;
            irda_select <= 1'b0;
            ask_select <= 1'b0;
            rx_blanked <= 1'b0;
        end
        else
        begin
            midi_enable <= serial_port_two_mode[MODE_MIDI_BIT];
            high_speed_enable <=
                serial_port_two_mode[MODE_HSPEED_BIT];
            irda_select <= (scheme == SCHEME_IRDA);
            ask_select <= (scheme == SCHEME_ASK);
            rx_blanked <= blank_on;
        end
    end
endmodule

/* sim/sp2_cfg_sva.sv */
// Assertions on the option block's ports.
// Assumes binding onto the top module; mirrors writes itself.
`timescale 1ns/1ns
module sp2_cfg_sva
    import sp2_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = 4
)
(
    input wire logic clk, // Core clock
    input wire logic nrst, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic uart_txd, // UART data
    input wire logic uart_tx_active, // UART sending
    input wire logic second_port_transmit_pin, // Pin level
    input wire logic second_port_transmit_oe, // Pin enable
    input wire logic midi_enable, // MIDI on
    input wire logic high_speed_enable, // High speed on
    input wire logic irda_select, // IrDA on
    input wire logic ask_select, // ASK on
    input wire logic rx_blanked // Blanked
);
    logic [7:0] mode_sh; // Mirror of mode
    logic [7:0] opt_sh; // Mirror of option
    // Mirror the two option registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_sh <= RST_MODE;
            opt_sh <= RST_IR_OPT;
        end
        else if (reg_write && reg_addr == OFS_MODE)
            mode_sh <= reg_wdata;
        else if (reg_write && reg_addr == OFS_IR_OPT)
            opt_sh <= reg_wdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Transmitter held busy in half duplex
    sequence s_tx_held;
        uart_tx_active [*2] ##0 opt_sh[IR_DUPLEX_BIT];
    endsequence
    a_rdata_rest: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not zero");
    a_mode_read: assert property (reg_read && reg_addr == OFS_MODE
        |=> reg_rdata == $past(mode_sh)) else $error("mode read wrong");
    a_opt_read: assert property (reg_read && reg_addr == OFS_IR_OPT
        |=> reg_rdata == $past(opt_sh)) else $error("option read wrong");
    a_unmapped_read: assert property (reg_read && reg_addr > OFS_STATUS
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_midi_follow: assert property (
        midi_enable == $past(mode_sh[MODE_MIDI_BIT])) else $error("midi");
    a_speed_follow: assert property (
        high_speed_enable == $past(mode_sh[MODE_HSPEED_BIT]))
        else $error("high speed");
    a_irda_decode: assert property (
        irda_select == ($past(opt_sh[5:3]) == IR_CODE_IRDA))
        else $error("irda decode");
    a_ask_decode: assert property (
        ask_select == ($past(opt_sh[5:3]) == IR_CODE_ASK))
        else $error("ask decode");
    a_idle_drive: assert property (!$past(uart_tx_active)
        |-> !second_port_transmit_pin
        && second_port_transmit_oe == !$past(mode_sh[MODE_TX_IDLE_BIT]))
        else $error("idle pin wrong");
    a_std_pass: assert property (
        $past(uart_tx_active && opt_sh[5:3] == IR_CODE_STD)
        |-> second_port_transmit_pin == $past(uart_txd))
        else $error("standard pass wrong");
    a_half_blank: assert property (s_tx_held |-> ##[0:2] rx_blanked)
        else $error("no blanking");
    a_full_clear: assert property (
        !$past(opt_sh[IR_DUPLEX_BIT]) |-> !rx_blanked)
        else $error("blank in full duplex");
endmodule
bind serial_port_ir_option_config sp2_cfg_sva
    #(.STEP_CYCLES(STEP_CYCLES)) i_sp2_cfg_sva
(
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .uart_txd(uart_txd), .uart_tx_active(uart_tx_active),
    .second_port_transmit_pin(second_port_transmit_pin),
    .second_port_transmit_oe(second_port_transmit_oe),
    .midi_enable(midi_enable), .high_speed_enable(high_speed_enable),
    .irda_select(irda_select), .ask_select(ask_select),
    .rx_blanked(rx_blanked)
);

/* sim/ir_peer.sv */
// Behavioural infrared transceiver at the block's pins.
// Assumes the bench asks for received light through send.
`timescale 1ns/1ns
module ir_peer
(
    input wire logic clk, // Core clock
    input wire logic tx_pin, // Transmit pin level
    input wire logic tx_oe, // Transmit pin enable
    input wire logic send, // Light falls on detector
    output logic rx_pin, // Detector output
    output logic [7:0] flashes // Emitter flashes seen
);
    logic last = 1'b0; // Previous lit state
    initial flashes = 8'h00;
    // Detector, active high on light
    always @(posedge clk)
        rx_pin <= send;
    // Released pin is dark; count rising light
    always @(posedge clk)
    begin
        last <= tx_pin & tx_oe;
        if ((tx_pin & tx_oe) && !last)
            flashes <= flashes + 8'h01;
    end
endmodule

/* sim/test_serial_port_ir_option_config.sv */
// Self-checking bench for the option block with a transceiver.
// Assumes a shortened blanking step of four clocks.
`timescale 1ns/1ns
module test_serial_port_ir_option_config;
    import sp2_cfg_pkg::*;
    localparam int STEP = 4; // Shortened blanking step
    logic clk = 1'b0, nrst = 1'b0; // Clock and reset
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata; // Bus
    logic reg_write = 1'b0, reg_read = 1'b0; // Strobes
    logic uart_txd = 1'b1, uart_tx_active = 1'b0; // UART side
    logic baud16_tick = 1'b0, send = 1'b0, ir_rx_pin; // Ticks, light
    logic uart_rxd, pin, oe, midi, hs, irda, ask, blanked; // Outputs
    logic [7:0] flashes, v; // Peer count, scratch
    logic [1:0] tcnt = 2'h0; // Tick divider
    int err_count = 0, checks = 0; // Tallies
    serial_port_ir_option_config #(.STEP_CYCLES(STEP))
        i_serial_port_ir_option_config
    (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
        .uart_txd(uart_txd), .uart_tx_active(uart_tx_active),
        .baud16_tick(baud16_tick), .ir_rx_pin(ir_rx_pin),
        .uart_rxd(uart_rxd), .second_port_transmit_pin(pin),
        .second_port_transmit_oe(oe), .midi_enable(midi),
        .high_speed_enable(hs), .irda_select(irda), .ask_select(ask),
        .rx_blanked(blanked)
    );
    ir_peer i_ir_peer
    (
        .clk(clk), .tx_pin(pin), .tx_oe(oe), .send(send),
        .rx_pin(ir_rx_pin), .flashes(flashes)
    );
    always #20 clk = ~clk;
    // Tick every fourth clock
    always @(posedge clk)
    begin
        tcnt <= tcnt + 2'h1;
        baud16_tick <= (tcnt == 2'h3);
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] s, e);
        checks++;
        if (s !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wait_n(input int n);
        // Returns on the edge; flop outputs still show pre-edge values
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata_of();
    endtask
    function automatic logic [7:0] reg_rdata_of();
        return rdata;
    endfunction
    task automatic t_defaults();
        rd(OFS_MODE, v);
        check("mode reset", v, 8'h00);
        rd(OFS_IR_OPT, v);
        check("option reset", v, 8'h02);
        rd(OFS_HD_TIMEOUT, v);
        check("timeout reset", v, 8'h03);
        rd(8'h10, v);
        check("unmapped read", v, 8'h00);
        $display("done defaults");
    endtask
    task automatic t_mode();
        logic [7:0] vals[3] = '{8'h01, 8'h02, 8'h03};
        foreach (vals[i])
        begin
            wr(OFS_MODE, vals[i]);
            rd(OFS_MODE, v);
            check("mode back", v, vals[i]);
            check("midi", 8'(midi), 8'(vals[i][0]));
            check("speed", 8'(hs), 8'(vals[i][1]));
        end
        check("idle pin", 8'(pin), 8'h00);
        check("idle oe", 8'(oe), 8'h01);
        wr(OFS_MODE, 8'h80);
        wait_n(2);
        check("tristate oe", 8'(oe), 8'h00);
        wr(OFS_MODE, 8'h00);
        $display("done mode");
    endtask
    task automatic t_scheme();
        for (int c = 0; c < 8; c++)
        begin
            wr(OFS_IR_OPT, {2'b00, 3'(c), 3'b000});
            wait_n(2);
            check("irda", 8'(irda), 8'(c == 3));
            check("ask", 8'(ask), 8'(c == 2));
        end
        $display("done scheme");
    endtask
    task automatic t_tx();
        logic [7:0] f0;
        uart_tx_active <= 1'b1;
        wr(OFS_IR_OPT, 8'h02);
        wait_n(3);
        check("std high", 8'(pin), 8'h01);
        uart_txd <= 1'b0;
        wait_n(3);
        check("std low", 8'(pin), 8'h00);
        wr(OFS_IR_OPT, 8'h1a);
        uart_txd <= 1'b1;
        wait_n(3);
        check("inverted idle", 8'(pin), 8'h01);
        wr(OFS_IR_OPT, 8'h18);
        wait_n(3);
        check("plain idle", 8'(pin), 8'h00);
        f0 = flashes;
        uart_txd <= 1'b0;
        wait_n(40);
        uart_txd <= 1'b1;
        wait_n(4);
        check("irda flashes", flashes - f0, 8'h01);
        wr(OFS_IR_OPT, 8'h10);
        f0 = flashes;
        uart_txd <= 1'b0;
        wait_n(100);
        uart_txd <= 1'b1;
        wait_n(4);
        f0 = flashes - f0;
        check("ask flashes", 8'(f0 >= 2 && f0 <= 3), 8'h01);
        uart_tx_active <= 1'b0;
        $display("done transmit");
    endtask
    task automatic t_rx();
        for (int p = 0; p < 2; p++)
            for (int l = 0; l < 2; l++)
            begin
                wr(OFS_IR_OPT, 8'(p));
                send <= 1'(l);
                wait_n(8);
                check("rx level", 8'(uart_rxd), 8'(l ^ p));
            end
        send <= 1'b0;
        wait_n(8);
        wr(OFS_IR_OPT, 8'h18);
        wait_n(8);
        send <= 1'b1;
        wait_n(4);
        send <= 1'b0;
        wait_n(8);
        check("ir rx pulse", 8'(uart_rxd), 8'h00);
        wait_n(80);
        check("ir rx idle", 8'(uart_rxd), 8'h01);
        $display("done receive");
    endtask
    task automatic t_reset();
        wr(OFS_HD_TIMEOUT, 8'h09);
        wr(OFS_IR_OPT, 8'h04);
        wr(OFS_MODE, 8'h81);
        nrst <= 1'b0;
        wait_n(2);
        nrst <= 1'b1;
        rd(OFS_MODE, v);
        check("mode rereset", v, 8'h00);
        rd(OFS_IR_OPT, v);
        check("option rereset", v, 8'h02);
        rd(OFS_HD_TIMEOUT, v);
        check("timeout rereset", v, 8'h03);
        check("midi rereset", 8'(midi), 8'h00);
        $display("done reset");
    endtask
    task automatic t_blank();
        int tv[3] = '{0, 1, 3};
        int n;
        wr(OFS_IR_OPT, 8'h04);
        foreach (tv[i])
        begin
            wr(OFS_HD_TIMEOUT, 8'(tv[i]));
            uart_tx_active <= 1'b1;
            wait_n(4);
            check("blank on", 8'(blanked), 8'h01);
            uart_tx_active <= 1'b0;
            n = 0;
            wait_n(1);
            while (blanked === 1'b1 && n < 100)
            begin
                n++;
                wait_n(1);
            end
            check("blank span", 8'(n >= tv[i] * STEP
                && n <= tv[i] * STEP + 4), 8'h01);
        end
        wr(OFS_IR_OPT, 8'h00);
        uart_tx_active <= 1'b1;
        wait_n(4);
        check("full duplex", 8'(blanked), 8'h00);
        uart_tx_active <= 1'b0;
        $display("done blanking");
    endtask
    initial
    begin
        #(40 * 20000);
        err_count++;
        stop_test();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_defaults();
        t_mode();
        t_scheme();
        t_tx();
        t_rx();
        t_blank();
        t_reset();
        stop_test();
    end
endmodule
